/* File: include/uls_pkg.sv */
// package: register map, field layout, reset values and encodings of the line status block
//
// How it works
// - FIFO mode: aggregate error bit rises when a receive character with an error tag enters the FIFO.
// - a host read of line status clears the aggregate error bit.
// - non-FIFO mode: transmitter-empty is 1 only when holding and shift stages empty.
// - FIFO mode: transmitter-empty is 1 only when transmit FIFO and shift stage empty.
// - non-FIFO mode: holding-empty sets when holding stage moves into shift stage.
// - non-FIFO mode: holding-empty clears when the host loads the holding stage.
// - FIFO mode: holding-empty follows the transmit FIFO empty indication.
// - transmit interrupt request while holding-empty and its enable are both set.
// - break bit sets after receive line stays low for one whole frame.
// - a continuous break loads exactly one break character into the receive FIFO.
// - framing error bit sets when the stop bit of a character is missing.
// - parity error bit sets when received parity mismatches configured parity.
// - FIFO mode: framing and parity bits show tags of the FIFO head.
// - overrun error sits at line status bit 1, zero without overrun.
// - character arriving into a full receive FIFO flags overrun and is dropped.
package uls_pkg;
	// byte addresses on the register bus
	localparam logic [3:0]  ULS_LINE_STATUS_OFS = 4'h0;
	localparam logic [3:0]  ULS_CONTROL_OFS     = 4'h4;
	localparam logic [3:0]  ULS_DIVISOR_OFS     = 4'h8;
	// line status bit positions
	localparam int          ULS_LS_OVERRUN      = 1;
	localparam int          ULS_LS_PARITY       = 2;
	localparam int          ULS_LS_FRAMING      = 3;
	localparam int          ULS_LS_BREAK        = 4;
	localparam int          ULS_LS_THR_EMPTY    = 5;
	localparam int          ULS_LS_TX_EMPTY     = 6;
	localparam int          ULS_LS_FIFO_ERR     = 7;
	// control register fields
	localparam int          ULS_CT_FIFO_MODE    = 0;
	localparam int          ULS_CT_THR_IRQ_EN   = 1;
	localparam int          ULS_CT_WLEN_LO      = 2;
	localparam int          ULS_CT_PAR_EN       = 4;
	localparam int          ULS_CT_PAR_EVEN     = 5;
	localparam int          ULS_CT_TWO_STOP     = 6;
	localparam int          ULS_CT_WIDTH        = 7;
	// reset values
	localparam logic [6:0]  ULS_CONTROL_RST     = 7'h0C;
	localparam logic [15:0] ULS_DIVISOR_RST     = 16'h0010;
	// receive FIFO depth that the tag tracker mirrors
	localparam int          ULS_FIFO_DEPTH      = 16;
	localparam int          ULS_PTR_W           = 4;
	localparam int          ULS_FRAME_W         = 20;
	// error tag layout {break, framing, parity}
	localparam logic [2:0]  ULS_TAG_BREAK       = 3'h4;
	// bus handshake states
	typedef enum logic [1:0] {
		ULS_BUS_IDLE = 2'b01,
		ULS_BUS_ACK  = 2'b10
	} uls_bus_state_t;
endpackage : uls_pkg

/* File: hw/uls_break_detect.sv */
// break detector: watches the receive pin for a frame-long low level
`timescale 1ns/1ps
module uls_break_detect
	import uls_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   rx_pin_in,
	input  wire logic [ULS_FRAME_W-1:0] frame_len_in,
	output logic                        brk_pulse_out,
	output logic                        in_break_out
);
	logic                   rx_meta_q;
	logic                   rx_sync_q;
	logic [ULS_FRAME_W-1:0] low_cnt_q;

	// two-stage synchroniser, the pin is asynchronous
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= rx_pin_in;
			rx_sync_q <= rx_meta_q;
		end
	end

	// count low time; one pulse per break, rearmed only by a high line
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_cnt_q     <= '0;
			brk_pulse_out <= 1'b0;
			in_break_out  <= 1'b0;
		end else begin
			brk_pulse_out <= 1'b0;
			if (rx_sync_q) begin
				low_cnt_q    <= '0;
				in_break_out <= 1'b0;
			end else if (!in_break_out) begin
				low_cnt_q <= low_cnt_q + 1'b1;
				if (low_cnt_q + 1'b1 >= frame_len_in) begin
					brk_pulse_out <= 1'b1;
					in_break_out  <= 1'b1;
				end
			end
		end
	end

	chk_break_single_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		brk_pulse_out |=> (!brk_pulse_out)[*2])
		else $error("break pulse repeated without the line going high");
endmodule : uls_break_detect

/* File: hw/uls_tag_tracker.sv */
// tag tracker: mirrors the receive FIFO holding only each character's error tags
`timescale 1ns/1ps
module uls_tag_tracker
	import uls_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       push_in,
	input  wire logic [2:0] push_tags_in,
	input  wire logic       pop_in,
	output logic [2:0]      head_tags_out,
	output logic            head_new_out,
	output logic            err_any_out
);
	logic [2:0]           tag_mem [ULS_FIFO_DEPTH];
	logic [ULS_PTR_W-1:0] wr_q;
	logic [ULS_PTR_W-1:0] rd_q;
	logic [ULS_PTR_W:0]   cnt_q;
	logic [ULS_PTR_W:0]   err_cnt_q;
	logic                 pop_ok;
	logic                 push_ok;

	// pops of an empty FIFO and pushes into a full one are ignored
	assign pop_ok        = pop_in && (cnt_q != '0);
	assign push_ok       = push_in && (cnt_q != (ULS_PTR_W+1)'(ULS_FIFO_DEPTH));
	assign head_tags_out = tag_mem[rd_q];
	assign err_any_out   = (err_cnt_q != '0);

	// tag storage, no reset needed: entries are read only once valid
	always_ff @(posedge clk_in) begin
		if (push_ok) begin
			tag_mem[wr_q] <= push_tags_in;
		end
	end

	// pointers, occupancy and count of errored entries
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q         <= '0;
			rd_q         <= '0;
			cnt_q        <= '0;
			err_cnt_q    <= '0;
			head_new_out <= 1'b0;
		end else begin
			wr_q      <= wr_q + ULS_PTR_W'(push_ok);
			rd_q      <= rd_q + ULS_PTR_W'(pop_ok);
			cnt_q     <= cnt_q + (ULS_PTR_W+1)'(push_ok) - (ULS_PTR_W+1)'(pop_ok);
			err_cnt_q <= err_cnt_q + (ULS_PTR_W+1)'(push_ok && (push_tags_in != 3'h0))
				- (ULS_PTR_W+1)'(pop_ok && (tag_mem[rd_q] != 3'h0));
			// a new character reaches the head of the FIFO
			head_new_out <= (push_ok && (cnt_q == '0)) || (pop_ok && (cnt_q > 1)) ||
				(pop_ok && push_ok && (cnt_q == 1));
		end
	end
endmodule : uls_tag_tracker

/* File: hw/uls_line_status.sv */
// line status logic: status register, error capture and Avalon-MM register slave
`timescale 1ns/1ps
module uls_line_status
	import uls_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// transmit side of the transceiver
	input  wire logic        thr_load_in,
	input  wire logic        thr_to_tsr_in,
	input  wire logic        tsr_empty_in,
	input  wire logic        tx_fifo_empty_in,
	// receive side of the transceiver
	input  wire logic        rx_pin_in,
	input  wire logic        rx_char_done_in,
	input  wire logic [7:0]  rx_char_data_in,
	input  wire logic        rx_char_par_bit_in,
	input  wire logic        rx_char_stop_bit_in,
	input  wire logic        rx_fifo_full_in,
	input  wire logic        rx_fifo_pop_in,
	// results
	output logic             rx_fifo_push_out,
	output logic [7:0]       rx_push_data_out,
	output logic             tx_irq_out,
	output logic [7:0]       line_status_out
);
	////////////////////////////////////////////////////////////////////////////////////////
	// declarations

	uls_bus_state_t         bus_state_q;
	logic [7:0]             rd_snap;
	logic                   bus_done;
	logic                   ls_read_done;
	logic                   ctrl_write;
	logic                   div_write;
	logic [31:0]            rdata_mux;

	logic [ULS_CT_WIDTH-1:0] ctrl_q;
	logic [15:0]            div_q;
	logic                   fifo_mode;
	logic [1:0]             wlen;
	logic [3:0]             frame_bits;
	logic [ULS_FRAME_W-1:0] frame_len_q;

	logic                   thr_empty_d;
	logic                   thr_empty_q;
	logic                   temt_q;

	logic [7:0]             data_mask;
	logic                   par_calc;
	logic                   pe_chk;
	logic                   fe_chk;
	logic                   brk_pulse;
	logic                   in_break;
	logic                   chr_ev;
	logic                   any_ev;
	logic                   blocked;
	logic                   ovr_set;
	logic                   push_d;
	logic [2:0]             tags_d;
	logic [2:0]             push_tags_q;

	logic [2:0]             head_tags;
	logic                   head_new;
	logic                   err_any;
	logic [4:1]             err_set;
	logic [4:1]             err_q;
	logic                   fifo_err_q;
	logic                   fifo_err_set;

	////////////////////////////////////////////////////////////////////////////////////////
	// register bus slave

	// completion edge is the cycle the slave holds waitrequest low
	assign bus_done     = (bus_state_q == ULS_BUS_ACK) && (avs_read_in || avs_write_in);
	assign ls_read_done = bus_done && avs_read_in && (avs_address_in == ULS_LINE_STATUS_OFS);
	assign ctrl_write   = bus_done && avs_write_in && (avs_address_in == ULS_CONTROL_OFS);
	assign div_write    = bus_done && avs_write_in && (avs_address_in == ULS_DIVISOR_OFS);
	// status bits shown to the host in this read; only these get cleared
	assign rd_snap      = ls_read_done ? avs_readdata_out[7:0] : 8'h00;

	// read data mux; unmapped addresses read zero
	always_comb begin
		rdata_mux = 32'h0000_0000;
		case (avs_address_in)
			ULS_LINE_STATUS_OFS: rdata_mux = {24'h00_0000, line_status_out};
			ULS_CONTROL_OFS:     rdata_mux = {25'h000_0000, ctrl_q};
			ULS_DIVISOR_OFS:     rdata_mux = {16'h0000, div_q};
			default:             rdata_mux = 32'h0000_0000;
		endcase
	end

	// every access costs exactly one wait cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_state_q         <= ULS_BUS_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0000_0000;
		end else begin
			case (bus_state_q)
				ULS_BUS_IDLE: begin
					if (avs_read_in || avs_write_in) begin
						bus_state_q         <= ULS_BUS_ACK;
						avs_waitrequest_out <= 1'b0;
						avs_readdata_out    <= avs_read_in ? rdata_mux : 32'h0000_0000;
					end
				end
				ULS_BUS_ACK: begin
					bus_state_q         <= ULS_BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
				default: begin
					bus_state_q         <= ULS_BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

	// control and divisor registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= ULS_CONTROL_RST;
			div_q  <= ULS_DIVISOR_RST;
		end else begin
			if (ctrl_write) begin
				ctrl_q <= avs_writedata_in[ULS_CT_WIDTH-1:0];
			end
			if (div_write) begin
				div_q <= avs_writedata_in[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// character format and frame length

	assign fifo_mode  = ctrl_q[ULS_CT_FIFO_MODE];
	assign wlen       = ctrl_q[ULS_CT_WLEN_LO +: 2];
	// start + 5..8 data + optional parity + one or two stop bits
	assign frame_bits = 4'h7 + {2'b00, wlen} + {3'b000, ctrl_q[ULS_CT_PAR_EN]} +
		{3'b000, ctrl_q[ULS_CT_TWO_STOP]};

	// registered product keeps the multiplier off the counter path
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_len_q <= '1;
		end else begin
			frame_len_q <= ULS_FRAME_W'(frame_bits) * ULS_FRAME_W'(div_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// transmitter status

	// a load in the same cycle as a transfer leaves the holding stage full
	always_comb begin
		thr_empty_d = thr_empty_q;
		if (fifo_mode) begin
			thr_empty_d = tx_fifo_empty_in;
		end else if (thr_load_in) begin
			thr_empty_d = 1'b0;
		end else if (thr_to_tsr_in) begin
			thr_empty_d = 1'b1;
		end
	end

	// both empty flags start set, the transmitter is idle after reset
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			thr_empty_q <= 1'b1;
			temt_q      <= 1'b1;
			tx_irq_out  <= 1'b0;
		end else begin
			thr_empty_q <= thr_empty_d;
			temt_q      <= (fifo_mode ? tx_fifo_empty_in : thr_empty_d) && tsr_empty_in;
			tx_irq_out  <= thr_empty_d && ctrl_q[ULS_CT_THR_IRQ_EN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// receive checks and FIFO loading

	uls_break_detect u_break (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.rx_pin_in     (rx_pin_in),
		.frame_len_in  (frame_len_q),
		.brk_pulse_out (brk_pulse),
		.in_break_out  (in_break)
	);

	assign data_mask = 8'hFF >> (2'd3 - wlen);
	assign par_calc  = ^(rx_char_data_in & data_mask);
	// even parity: parity bit equals xor of data bits
	assign pe_chk    = ctrl_q[ULS_CT_PAR_EN] &&
		(rx_char_par_bit_in != (ctrl_q[ULS_CT_PAR_EVEN] ? par_calc : ~par_calc));
	assign fe_chk    = !rx_char_stop_bit_in;

	// characters framed during a break are the break itself, not new data
	assign chr_ev  = rx_char_done_in && !in_break;
	assign any_ev  = brk_pulse || chr_ev;
	assign blocked = rx_fifo_full_in && !rx_fifo_pop_in;
	assign ovr_set = any_ev && blocked;
	assign push_d  = any_ev && !blocked;
	assign tags_d  = brk_pulse ? ULS_TAG_BREAK : {1'b0, fe_chk, pe_chk};

	// push strobe, data and tags toward the receive FIFO
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_fifo_push_out <= 1'b0;
			rx_push_data_out <= 8'h00;
			push_tags_q      <= 3'h0;
		end else begin
			rx_fifo_push_out <= push_d;
			push_tags_q      <= push_d ? tags_d : 3'h0;
			if (push_d) begin
				rx_push_data_out <= brk_pulse ? 8'h00 : (rx_char_data_in & data_mask);
			end
		end
	end

	uls_tag_tracker u_tags (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.push_in       (rx_fifo_push_out),
		.push_tags_in  (push_tags_q),
		.pop_in        (rx_fifo_pop_in),
		.head_tags_out (head_tags),
		.head_new_out  (head_new),
		.err_any_out   (err_any)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// sticky error bits

	// FIFO mode reports the head character, otherwise the latest one
	always_comb begin
		err_set[ULS_LS_OVERRUN] = ovr_set;
		if (fifo_mode) begin
			err_set[4:2] = head_new ? head_tags : 3'h0;
		end else begin
			err_set[4:2] = push_tags_q;
		end
	end

	// set beats the read clear so no event slips between snapshot and clear
	for (genvar i = 1; i <= 4; i++) begin : g_err
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				err_q[i] <= 1'b0;
			end else begin
				err_q[i] <= (err_q[i] && !rd_snap[i]) || err_set[i];
			end
		end
	end

	// aggregate bit only rises for a new errored entry in FIFO mode
	assign fifo_err_set = fifo_mode && rx_fifo_push_out && (push_tags_q != 3'h0);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fifo_err_q <= 1'b0;
		end else begin
			fifo_err_q <= (fifo_err_q && err_any && !rd_snap[ULS_LS_FIFO_ERR]) ||
				fifo_err_set;
		end
	end

	// bit 0 belongs to the receiver data-ready logic and reads zero here
	assign line_status_out = {fifo_err_q, temt_q, thr_empty_q, err_q, 1'b0};

	////////////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_thr_empty_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!fifo_mode && thr_to_tsr_in && !thr_load_in |=> thr_empty_q)
		else $error("holding-empty did not set on transfer to shift stage");

	chk_thr_empty_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!fifo_mode && thr_load_in |=> !thr_empty_q)
		else $error("holding-empty did not clear on holding load");

	chk_tx_empty_busy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!tsr_empty_in |=> !temt_q && $past(!tsr_empty_in))
		else $error("transmitter-empty set while shift stage busy");

	chk_tx_irq_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!fifo_mode && thr_to_tsr_in && !thr_load_in && ctrl_q[ULS_CT_THR_IRQ_EN] &&
		!ctrl_write ##1 1'b1 |=> tx_irq_out == thr_empty_q)
		else $error("transmit interrupt does not follow holding-empty");

	chk_overrun_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_char_done_in && !in_break && !brk_pulse && rx_fifo_full_in && !rx_fifo_pop_in
		|=> err_q[ULS_LS_OVERRUN] && !rx_fifo_push_out)
		else $error("overrun not flagged or character pushed into full FIFO");

	chk_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ls_read_done && (avs_readdata_out[4:1] == err_q) && (err_set == 4'h0)
		|=> err_q == 4'h0)
		else $error("line status read did not clear error bits");

	chk_agg_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ls_read_done && avs_readdata_out[ULS_LS_FIFO_ERR] && !fifo_err_set |=> !fifo_err_q)
		else $error("aggregate error bit survived line status read");

	chk_agg_no_error: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!err_any && !fifo_err_set |=> !fifo_err_q)
		else $error("aggregate error bit high with no errored entry");

	chk_bus_one_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1
		avs_waitrequest_out)
		else $error("bus answer not given after exactly one wait cycle");
endmodule : uls_line_status

/* File: sim/uls_host_model.sv */
// host model: Avalon-MM master steered by the bench through one task
`timescale 1ns/1ps
module uls_host_model (
	input  wire logic        clk_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic        wait_in,
	output logic [3:0]       addr_out,
	output logic             rd_out,
	output logic             wr_out,
	output logic [31:0]      wdata_out
);
	// idle bus from time zero
	initial begin
		addr_out = 4'h0;
		rd_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 32'h0;
	end

	//////////////////////////////////////////////////////////////////////////
	// one access; the request stands until waitrequest is seen low at an edge
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		rd_out <= !w;
		wr_out <= w;
		do @(posedge clk_in); while (wait_in !== 1'b0);
		q = rdata_in;
		rd_out <= 1'b0;
		wr_out <= 1'b0;
	endtask : xfer
endmodule : uls_host_model

/* File: sim/tb.sv */
// testbench: line status block with host model and transceiver stimulus
`timescale 1ns/1ps
module tb;
	import uls_pkg::*;
	typedef struct packed {logic fifo, load, xfer, tsr_e, fifo_e, e5, e6;} uls_row_t;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [3:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        thr_load = 1'b0, thr_to_tsr = 1'b0, tsr_empty = 1'b1, tx_fifo_empty = 1'b1;
	logic        rx_pin = 1'b1, rx_done = 1'b0, rx_par = 1'b0, rx_stop = 1'b1;
	logic [7:0]  rx_data = 8'h00, push_data, line_status, push_dat;
	logic        rx_full = 1'b0, rx_pop = 1'b0, push, tx_irq;
	int          n_mismatch = 0, cmp_count = 0, push_cnt = 0, cnt0;
	// transmit steps: first five without FIFO, rest in FIFO mode
	localparam uls_row_t ROWS [9] = '{
		'{0,1,0,1,1,0,0}, '{0,0,1,0,1,1,0}, '{0,0,0,1,1,1,1}, '{0,1,1,1,1,0,0},
		'{0,0,1,1,1,1,1}, '{1,0,0,1,0,0,0}, '{1,1,0,1,0,0,0}, '{1,0,0,0,1,1,0},
		'{1,0,1,1,1,1,1}};

	always #2.5 clk_in = ~clk_in;

	uls_host_model host (.clk_in(clk_in), .rdata_in(avs_readdata),
		.wait_in(avs_waitrequest), .addr_out(avs_address), .rd_out(avs_read),
		.wr_out(avs_write), .wdata_out(avs_writedata));

	uls_line_status DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
		.avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest), .thr_load_in(thr_load),
		.thr_to_tsr_in(thr_to_tsr), .tsr_empty_in(tsr_empty),
		.tx_fifo_empty_in(tx_fifo_empty), .rx_pin_in(rx_pin), .rx_char_done_in(rx_done),
		.rx_char_data_in(rx_data), .rx_char_par_bit_in(rx_par),
		.rx_char_stop_bit_in(rx_stop), .rx_fifo_full_in(rx_full),
		.rx_fifo_pop_in(rx_pop), .rx_fifo_push_out(push), .rx_push_data_out(push_data),
		.tx_irq_out(tx_irq), .line_status_out(line_status));

	// push monitor: counts pushes, keeps the last data
	always @(posedge clk_in) if (push === 1'b1) begin
		push_cnt++;
		push_dat = push_data;
	end

	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// reset for 20 cycles, outputs looked at while it is held
	task automatic do_reset();
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		chk("status in reset", 8'h60, line_status);
		chk("irq in reset", 1'b0, tx_irq);
		rst_n_in <= 1'b1;
	endtask : do_reset

	task automatic rx_char(input logic [7:0] d, input logic p, input logic s);
		@(posedge clk_in);
		rx_done <= 1'b1;
		rx_data <= d;
		rx_par <= p;
		rx_stop <= s;
		@(posedge clk_in);
		rx_done <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
	endtask : rx_char

	task automatic pop();
		@(posedge clk_in);
		rx_pop <= 1'b1;
		@(posedge clk_in);
		rx_pop <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
	endtask : pop

	// status read, then a settle so the read clear has landed
	task automatic rd_status();
		host.xfer(1'b0, ULS_LINE_STATUS_OFS, 32'h0, q);
		#1;
	endtask : rd_status

	//////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		do_reset();
		// transmit table; strobes last one cycle, levels stay for the row
		for (int i = 0; i < 9; i++) begin
			if (i == 0 || i == 5)
				host.xfer(1'b1, ULS_CONTROL_OFS, 32'h0E | ROWS[i].fifo, q);
			@(posedge clk_in);
			thr_load <= ROWS[i].load;
			thr_to_tsr <= ROWS[i].xfer;
			tsr_empty <= ROWS[i].tsr_e;
			tx_fifo_empty <= ROWS[i].fifo_e;
			@(posedge clk_in);
			thr_load <= 1'b0;
			thr_to_tsr <= 1'b0;
			@(posedge clk_in);
			#1;
			chk("holding empty", ROWS[i].e5, line_status[5]);
			chk("tx empty", ROWS[i].e6, line_status[6]);
			chk("tx irq", ROWS[i].e5, tx_irq);
		end
		$display("test transmit table done");
		// second reset in mid-run, then register map
		do_reset();
		host.xfer(1'b0, ULS_LINE_STATUS_OFS, 32'h0, q);
		chk("status read", 32'h60, q);
		host.xfer(1'b1, ULS_LINE_STATUS_OFS, 32'hFF, q);
		host.xfer(1'b0, ULS_LINE_STATUS_OFS, 32'h0, q);
		chk("status after write", 32'h60, q);
		host.xfer(1'b0, ULS_CONTROL_OFS, 32'h0, q);
		chk("control reset", 32'h0C, q);
		host.xfer(1'b0, ULS_DIVISOR_OFS, 32'h0, q);
		chk("divisor reset", 32'h10, q);
		host.xfer(1'b0, 4'hC, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		$display("test reset and map done");
		// framing error without FIFO, cleared by a status read
		cnt0 = push_cnt;
		rx_char(8'h55, 1'b0, 1'b0);
		chk("push count", cnt0 + 1, push_cnt);
		chk("push data", 8'h55, push_dat);
		chk("framing bit", 1'b1, line_status[3]);
		rd_status();
		chk("framing read", 1'b1, q[3]);
		chk("framing cleared", 1'b0, line_status[3]);
		// even parity: one set bit with parity 0 is wrong, two set bits are fine
		host.xfer(1'b1, ULS_CONTROL_OFS, 32'h3C, q);
		rx_char(8'h01, 1'b0, 1'b1);
		chk("parity bit", 1'b1, line_status[2]);
		rd_status();
		chk("parity cleared", 1'b0, line_status[2]);
		rx_char(8'h03, 1'b0, 1'b1);
		chk("parity good", 1'b0, line_status[2]);
		// odd parity on 7-bit words: bit 7 of the character must be masked off
		host.xfer(1'b1, ULS_CONTROL_OFS, 32'h18, q);
		rx_char(8'h81, 1'b0, 1'b1);
		chk("odd parity good", 1'b0, line_status[2]);
		chk("7-bit push data", 8'h01, push_dat);
		rx_char(8'h01, 1'b1, 1'b1);
		chk("odd parity bit", 1'b1, line_status[2]);
		// overrun: character into a full FIFO is not pushed
		@(posedge clk_in);
		rx_full <= 1'b1;
		cnt0 = push_cnt;
		rx_char(8'hAA, 1'b0, 1'b1);
		chk("overrun push", cnt0, push_cnt);
		chk("overrun bit", 1'b1, line_status[1]);
		rd_status();
		chk("overrun read", 1'b1, q[1]);
		chk("overrun cleared", 1'b0, line_status[1]);
		@(posedge clk_in);
		rx_full <= 1'b0;
		$display("test receive errors done");
		// FIFO mode: tags follow the head; fresh reset empties the tag mirror
		do_reset();
		host.xfer(1'b1, ULS_CONTROL_OFS, 32'h0D, q);
		rx_char(8'h11, 1'b0, 1'b1);
		rx_char(8'h22, 1'b0, 1'b0);
		chk("head framing", 1'b0, line_status[3]);
		chk("fifo error", 1'b1, line_status[7]);
		pop();
		chk("next head framing", 1'b1, line_status[3]);
		rd_status();
		chk("fifo error read", 1'b1, q[7]);
		chk("fifo error cleared", 1'b0, line_status[7]);
		pop();
		chk("fifo error empty", 1'b0, line_status[7]);
		$display("test fifo tags done");
		// break: 8N1 with divisor 2 gives a frame of 20 clocks
		host.xfer(1'b1, ULS_DIVISOR_OFS, 32'h2, q);
		cnt0 = push_cnt;
		@(posedge clk_in);
		rx_pin <= 1'b0;
		// 10 bits of 2 clocks: push is due 2 sync + 20 count + 1 register edges on
		repeat (22) @(posedge clk_in);
		#1;
		chk("break early", cnt0, push_cnt);
		repeat (2) @(posedge clk_in);
		#1;
		chk("break on time", cnt0 + 1, push_cnt);
		repeat (200) @(posedge clk_in);
		rx_pin <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		chk("break pushes", cnt0 + 1, push_cnt);
		chk("break data", 8'h00, push_dat);
		chk("break bit", 1'b1, line_status[4]);
		chk("break fifo error", 1'b1, line_status[7]);
		// holding empty with its interrupt enable off
		chk("irq masked", 1'b0, tx_irq);
		chk("holding empty fifo", 1'b1, line_status[5]);
		$display("test break done");
		print_verdict();
	end
endmodule : tb
